// file: htec_pkg.sv
package htec_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] HTEC_CTRL_OFF   = 12'h000;
  localparam logic [11:0] HTEC_EXP_OFF    = 12'h004;
  localparam logic [11:0] HTEC_DLY_OFF    = 12'h008;
  localparam logic [11:0] HTEC_STAT_OFF   = 12'h00C;
  localparam logic [11:0] HTEC_CMD_OFF    = 12'h010;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int HTEC_CTL_TRIG_ON   = 0;
  localparam int HTEC_CTL_ORIGIN_HW = 1;
  localparam int HTEC_CTL_EDGE_FALL = 2;
  localparam int HTEC_CTL_PULSE     = 3;
  localparam int HTEC_CTL_RATE_ON   = 4;
  localparam int HTEC_CTL_KIND_AS   = 5;

  // Command and status bits
  localparam int HTEC_CMD_ACQ_START = 0;
  localparam int HTEC_CMD_ACQ_STOP  = 1;
  localparam int HTEC_CMD_SW_TRIG   = 2;
  localparam int HTEC_ST_OVT        = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [5:0]  HTEC_CTRL_RST = 6'h23;
  localparam logic [23:0] HTEC_EXP_RST  = 24'h00_0BB8;
  localparam logic [23:0] HTEC_DLY_RST  = 24'h00_0000;
  localparam int HTEC_CLK_MHZ    = 50;
  localparam int HTEC_US_NS      = 1000;
  localparam int HTEC_CLK_NS     = 20;
  localparam int HTEC_CYC_PER_US = HTEC_US_NS / HTEC_CLK_NS;

  typedef enum logic [2:0] {
    HTEC_IDLE,
    HTEC_WAIT,
    HTEC_DELAY,
    HTEC_EXPOSE,
    HTEC_HOLD
  } htec_state_t;

  typedef struct packed {
    logic expose;
    logic frame_start;
    logic ready;
  } htec_sens_t;

endpackage

// file: htec_core.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module htec_core
  import htec_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger line and sequencer
  input  wire logic        external_start_trigger,
  input  wire logic        readout_busy,
  output htec_sens_t       sens
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 8 || CNT_W > 31) begin : g_cnt_w_bad
    $error("CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]       ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] exp_r, exp_nxt;
  logic [CNT_W-1:0] dly_r, dly_nxt;
  logic             ovt_r, ovt_nxt;
  logic             acq_r, acq_nxt;
  logic             trig_d_r;
  htec_state_t      st_r, st_nxt;
  logic [CNT_W-1:0] us_cnt_r, us_cnt_nxt;
  logic [5:0]       div_r, div_nxt;
  logic             min_done_r, min_done_nxt;
  logic [31:0]      prdata_nxt;

  wire logic wr = psel && penable && pwrite;
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic trig_on   = ctrl_r[HTEC_CTL_TRIG_ON] && ctrl_r[HTEC_CTL_KIND_AS];
  wire logic hw_origin = ctrl_r[HTEC_CTL_ORIGIN_HW];
  wire logic fall_sel  = ctrl_r[HTEC_CTL_EDGE_FALL];
  wire logic pulse_md  = ctrl_r[HTEC_CTL_PULSE];
  wire logic sw_trig   = wr && paddr == HTEC_CMD_OFF && pwdata[HTEC_CMD_SW_TRIG];

  // ----------------------------------------------------------------
  // Trigger edge detect
  // ----------------------------------------------------------------
  // Active level of the trigger for the chosen edge
  function automatic logic act_lvl(input logic lvl, input logic fall);
    return fall ? !lvl : lvl;
  endfunction

  wire logic act_now  = act_lvl(external_start_trigger, fall_sel);
  wire logic act_prev = act_lvl(trig_d_r, fall_sel);
  wire logic hw_edge  = act_now && !act_prev && trig_on && hw_origin;
  wire logic any_trig = hw_edge || (sw_trig && trig_on && !hw_origin);
  wire logic us_tick  = div_r == 6'(HTEC_CYC_PER_US - 1);
  wire logic busy     = st_r == HTEC_DELAY || st_r == HTEC_EXPOSE || st_r == HTEC_HOLD;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // Register and command next state
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    exp_nxt    = exp_r;
    dly_nxt    = dly_r;
    acq_nxt    = acq_r;
    ovt_nxt    = ovt_r;
    prdata_nxt = prdata;
    if (wr) begin
      case (paddr)
        HTEC_CTRL_OFF: ctrl_nxt = pwdata[5:0];
        HTEC_EXP_OFF:  exp_nxt  = pwdata[CNT_W-1:0];
        HTEC_DLY_OFF:  dly_nxt  = pwdata[CNT_W-1:0];
        HTEC_STAT_OFF: if (pwdata[HTEC_ST_OVT]) ovt_nxt = 1'b0;
        HTEC_CMD_OFF: begin
          if (pwdata[HTEC_CMD_ACQ_START]) acq_nxt = 1'b1;
          if (pwdata[HTEC_CMD_ACQ_STOP])  acq_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (any_trig && (busy || (st_r == HTEC_IDLE && acq_r) ||
                     (st_r == HTEC_WAIT && !min_done_r))) begin
      ovt_nxt = 1'b1;
    end
    if (rd_setup) begin
      case (paddr)
        HTEC_CTRL_OFF: prdata_nxt = {26'h000_0000, ctrl_r};
        HTEC_EXP_OFF:  prdata_nxt = 32'(exp_r);
        HTEC_DLY_OFF:  prdata_nxt = 32'(dly_r);
        HTEC_STAT_OFF: prdata_nxt = {27'h000_0000, readout_busy, sens.expose,
                                     st_r == HTEC_WAIT, acq_r, ovt_r};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    us_cnt_nxt   = us_cnt_r;
    min_done_nxt = min_done_r;
    div_nxt      = us_tick ? 6'h00 : div_r + 6'h01;
    // Minimum exposure timer runs on after a short pulse, ready waits for it
    if (st_r == HTEC_EXPOSE || st_r == HTEC_HOLD || st_r == HTEC_WAIT) begin
      if (us_tick && !min_done_r) us_cnt_nxt = us_cnt_r + 1'b1;
      if (us_tick && us_cnt_r + 1'b1 >= exp_r) min_done_nxt = 1'b1;
    end
    case (st_r)
      HTEC_IDLE: begin
        min_done_nxt = 1'b1;
        if (acq_r) st_nxt = HTEC_WAIT;
      end
      HTEC_WAIT: begin
        if (!acq_r) begin
          st_nxt = HTEC_IDLE;
        end else if (any_trig && min_done_r) begin
          div_nxt      = 6'h00;
          us_cnt_nxt   = '0;
          min_done_nxt = 1'b0;
          if (hw_edge && dly_r != '0) st_nxt = HTEC_DELAY;
          else                        st_nxt = HTEC_EXPOSE;
        end
      end
      HTEC_DELAY: begin
        if (us_tick) us_cnt_nxt = us_cnt_r + 1'b1;
        if (us_tick && us_cnt_r + 1'b1 >= dly_r) begin
          st_nxt     = HTEC_EXPOSE;
          us_cnt_nxt = '0;
        end
      end
      HTEC_EXPOSE: begin
        if (!pulse_md) begin
          if (min_done_r) st_nxt = HTEC_WAIT;
        end else if (!act_now) begin
          st_nxt = readout_busy ? HTEC_HOLD : HTEC_WAIT;
        end
      end
      HTEC_HOLD: if (!readout_busy) st_nxt = HTEC_WAIT;
      default:   st_nxt = HTEC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= HTEC_CTRL_RST;
      exp_r      <= CNT_W'(HTEC_EXP_RST);
      dly_r      <= CNT_W'(HTEC_DLY_RST);
      ovt_r      <= 1'b0;
      acq_r      <= 1'b0;
      trig_d_r   <= 1'b0;
      st_r       <= HTEC_IDLE;
      us_cnt_r   <= '0;
      div_r      <= 6'h00;
      min_done_r <= 1'b1;
      prdata     <= 32'h0000_0000;
    end else begin
      ctrl_r     <= ctrl_nxt;
      exp_r      <= exp_nxt;
      dly_r      <= dly_nxt;
      ovt_r      <= ovt_nxt;
      acq_r      <= acq_nxt;
      trig_d_r   <= external_start_trigger;
      st_r       <= st_nxt;
      us_cnt_r   <= us_cnt_nxt;
      div_r      <= div_nxt;
      min_done_r <= min_done_nxt;
      prdata     <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sensor outputs
  // ----------------------------------------------------------------
  always_comb begin
    sens.expose      = st_r == HTEC_EXPOSE || st_r == HTEC_HOLD;
    sens.frame_start = st_r != HTEC_EXPOSE && st_nxt == HTEC_EXPOSE;
    sens.ready       = st_r == HTEC_WAIT && min_done_r;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OVT_SET: assert property (any_trig && busy |=> ovt_r)
    else $error("overtrigger not flagged");
  AST_BUSY_NOSTART: assert property (
    (st_r == HTEC_EXPOSE || st_r == HTEC_HOLD) && any_trig |=> !sens.frame_start)
    else $error("trigger accepted while busy");
  AST_EDGE_START: assert property (st_r == HTEC_WAIT && acq_r && min_done_r && hw_edge
      && dly_r == '0 |=> st_r == HTEC_EXPOSE)
    else $error("edge did not start exposure");
  AST_DELAY_USED: assert property (st_r == HTEC_WAIT && acq_r && min_done_r && hw_edge
      && dly_r != '0 |=> st_r == HTEC_DELAY)
    else $error("delay skipped");
  AST_SW_NODELAY: assert property (st_r == HTEC_WAIT && acq_r && min_done_r && any_trig
      && !hw_origin |=> st_r == HTEC_EXPOSE)
    else $error("software trigger delayed");
  AST_TIMED_END: assert property (st_r == HTEC_EXPOSE && !pulse_md && !min_done_r
      |=> st_r == HTEC_EXPOSE)
    else $error("timed exposure ended early");
  AST_PULSE_HOLD: assert property (st_r == HTEC_EXPOSE && pulse_md && act_now
      |=> st_r == HTEC_EXPOSE)
    else $error("pulse exposure ended while active");
  AST_PULSE_EXT: assert property (st_r == HTEC_EXPOSE && pulse_md && !act_now && readout_busy
      |=> st_r == HTEC_HOLD ##0 sens.expose)
    else $error("exposure not extended over readout");
  AST_PULSE_END: assert property (st_r == HTEC_EXPOSE && pulse_md && !act_now && !readout_busy
      |=> st_r == HTEC_WAIT)
    else $error("pulse exposure did not end");
  AST_READY_MIN: assert property (!min_done_r |-> !sens.ready)
    else $error("ready before minimum exposure");

  // ----------------------------------------------------------------
  // Sequencer checks
  // ----------------------------------------------------------------
  AST_WAITMIN_DROP: assert property (
    st_r == HTEC_WAIT && acq_r && !min_done_r && any_trig
    |=> st_r == HTEC_WAIT && ovt_r)
    else $error("trigger taken before minimum exposure");
  AST_HOLD_STAY: assert property (
    st_r == HTEC_HOLD && readout_busy
    |=> st_r == HTEC_HOLD)
    else $error("extension ended during readout");
  AST_HOLD_END: assert property (
    st_r == HTEC_HOLD && !readout_busy
    |=> st_r == HTEC_WAIT)
    else $error("extension outlived readout");
  AST_FALL_EDGE: assert property (
    st_r == HTEC_WAIT && acq_r && min_done_r && trig_on && hw_origin && fall_sel
    && trig_d_r && !external_start_trigger |=> st_r == HTEC_EXPOSE || st_r == HTEC_DELAY)
    else $error("falling edge not taken");
  AST_RISE_ONLY: assert property (
    st_r == HTEC_WAIT && !fall_sel && !sw_trig && !external_start_trigger
    |=> st_r != HTEC_EXPOSE && st_r != HTEC_DELAY)
    else $error("low line started a frame");
  AST_FRAME_EXPOSE: assert property (
    sens.frame_start
    |=> sens.expose)
    else $error("frame start without exposure");
  AST_DELAY_WAITS: assert property (
    st_r == HTEC_DELAY && !us_tick
    |=> st_r == HTEC_DELAY)
    else $error("delay cut short");
  AST_OVT_STICKY: assert property (
    ovt_r && !(wr && paddr == HTEC_STAT_OFF)
    |=> ovt_r)
    else $error("overtrigger flag lost");
  AST_IDLE_DROP: assert property (
    st_r == HTEC_IDLE && !acq_r
    |=> st_r == HTEC_IDLE)
    else $error("left idle without acquisition");
  AST_PULSE_FALL: assert property (
    st_r == HTEC_EXPOSE && pulse_md && fall_sel && !external_start_trigger
    |=> st_r == HTEC_EXPOSE)
    else $error("falling pulse exposure ended while low");

  COV_TIMED: cover property (st_r == HTEC_EXPOSE && !pulse_md ##1 st_r == HTEC_WAIT);
  COV_PULSE: cover property (st_r == HTEC_EXPOSE && pulse_md ##1 st_r == HTEC_WAIT);
  COV_HOLD:  cover property (st_r == HTEC_HOLD ##1 st_r == HTEC_WAIT);
  COV_OVT:   cover property (any_trig && busy);
  COV_DELAY: cover property (st_r == HTEC_DELAY ##1 st_r == HTEC_EXPOSE);

endmodule // htec_core

// file: htec_trig_src.sv
`timescale 1ns/1ps
// ------------------------------
// Trigger source on the input line
// ------------------------------
module htec_trig_src (
  // Clock
  input  wire logic pclk,
  // Line
  output logic      line
);
  initial line = 1'b0;
  // Active level for w cycles, then back
  task automatic pulse(input logic act, input int w);
    @(posedge pclk) line <= act;
    repeat (w) @(posedge pclk);
    line <= ~act;
  endtask
  task automatic level(input logic v);
    @(posedge pclk) line <= v;
  endtask
endmodule // htec_trig_src

// file: test_hw_trigger_exposure_control.sv
`timescale 1ns/1ps
module test_hw_trigger_exposure_control
  import htec_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, line, readout_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  htec_sens_t  sens;
  int          num_errors, compares, seed, lat, len, bad, i, w, ro, ex;

  htec_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_start_trigger(line), .readout_busy(readout_busy),
    .sens(sens));
  htec_trig_src src (.pclk(pclk), .line(line));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] ctl(input logic fall, input logic pw);
    return 32'h0000_0023 | (32'(fall) << HTEC_CTL_EDGE_FALL) | (32'(pw) << HTEC_CTL_PULSE);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[ERR] t=%0t pready=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One frame: latency to exposure, its length, cycles exposing while ready
  task automatic frame(input logic act, input int w, input logic re);
    int t;
    lat = 0;
    len = 0;
    bad = 0;
    fork
      begin
        src.pulse(act, w);
        if (re) begin
          repeat (20) @(posedge pclk);
          src.pulse(act, 5);
        end
      end
      for (t = 0; t < 3000 && !(len > 0 && sens.expose === 1'b0); t++) begin
        @(posedge pclk);
        if (sens.expose === 1'b1) len++;
        else if (len == 0) lat++;
        if (sens.expose === 1'b1 && sens.ready !== 1'b0) bad++;
      end
    join
    repeat (4) @(posedge pclk);
  endtask

  task automatic results;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(40000 * 20);
    num_errors++;
    results();
  end

  initial begin
    seed = 37130;
    num_errors = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, readout_busy} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(sens), 0, 0);
    apb(1'b0, HTEC_CTRL_OFF, 0);
    chk(rd, 32'h0000_0023, 32'h0000_0023);
    apb(1'b0, 12'h014, 0);
    chk(rd, 0, 0);
    apb(1'b1, HTEC_EXP_OFF, 32'h0000_0002);
    apb(1'b1, HTEC_CMD_OFF, 32'h0000_0001);
    // Timed mode, both edges; a retrigger mid-exposure is dropped
    for (i = 0; i < 2; i++) begin
      apb(1'b1, HTEC_CTRL_OFF, ctl(i[0], 1'b0));
      src.level(i[0]);
      repeat (4) @(posedge pclk);
      chk(32'(sens.ready), 1, 1);
      frame(~i[0], 5, 1'b1);
      chk(lat, 0, 4);
      chk(len, 2 * HTEC_CYC_PER_US, 2 * HTEC_CYC_PER_US + 2);
      apb(1'b0, HTEC_STAT_OFF, 0);
      chk(32'(rd[HTEC_ST_OVT]), 1, 1);
      apb(1'b1, HTEC_STAT_OFF, 32'h0000_0001);
    end
    $display("test timed done");
    // Pulse-width mode, random widths, alternating edges
    for (i = 0; i < 4; i++) begin
      w = 120 + ($unsigned($random(seed)) % 200);
      apb(1'b1, HTEC_CTRL_OFF, ctl(i[0], 1'b1));
      src.level(i[0]);
      repeat (4) @(posedge pclk);
      frame(~i[0], w, 1'b0);
      chk(len, w - 2, w + 2);
      chk(bad, 0, 0);
    end
    // Short falling pulse: ready waits for the minimum, early retrigger dropped
    frame(1'b0, 30, 1'b1);
    chk(len, 28, 32);
    chk(32'(sens.ready), 0, 0);
    lat = 0;
    while (sens.ready !== 1'b1 && lat < 200) begin
      @(posedge pclk);
      lat++;
    end
    chk(lat, 30, 55);
    apb(1'b0, HTEC_STAT_OFF, 0);
    chk(32'(rd[HTEC_ST_OVT]), 1, 1);
    apb(1'b1, HTEC_STAT_OFF, 32'h0000_0001);
    $display("test pulse done");
    apb(1'b1, HTEC_CTRL_OFF, ctl(1'b0, 1'b1));
    src.level(1'b0);
    repeat (4) @(posedge pclk);
    // Trigger ends during readout, then after it
    for (i = 0; i < 2; i++) begin
      ro = i ? 60 : 250;
      ex = (ro > 150) ? ro : 150;
      readout_busy <= 1'b1;
      fork
        frame(1'b1, 150, 1'b0);
        begin
          repeat (ro) @(posedge pclk);
          readout_busy <= 1'b0;
        end
      join
      chk(len, ex - 4, ex + 2);
    end
    $display("test readout done");
    // Delay on the line trigger, none for a software trigger
    apb(1'b1, HTEC_DLY_OFF, 32'h0000_0001);
    apb(1'b1, HTEC_CTRL_OFF, ctl(1'b0, 1'b0));
    frame(1'b1, 5, 1'b0);
    chk(lat, HTEC_CYC_PER_US, HTEC_CYC_PER_US + 4);
    apb(1'b1, HTEC_CTRL_OFF, 32'h0000_0021);
    apb(1'b1, HTEC_CMD_OFF, 32'h0000_0004);
    lat = 0;
    while (sens.expose !== 1'b1 && lat < 200) begin
      @(posedge pclk);
      lat++;
    end
    chk(lat, 0, 3);
    $display("test delay done");
    results();
  end
endmodule // test_hw_trigger_exposure_control
